// file: design/kse_top.sv
// Keyboard scan and encode top: matrix scan, code issue, auto-repeat, bell tone, status lights.
// Assumes an AXI4-Lite master on the system clock and raw key pins needing synchronisers.
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "kse_regs.svh"
module kse_top
   import kse_pkg::*;
#(
   parameter int ROWS = 8,
   parameter int COLS = 8,
   parameter int TW = 26,
   parameter int RPT_DELAY_CYC = `KSE_CLK_HZ / 1000 * `KSE_RPT_DELAY_MS,
   parameter int RPT_PERIOD_CYC = `KSE_CLK_HZ / `KSE_RPT_RATE_HZ,
   parameter int TONE_CYC = `KSE_CLK_HZ / 1000 * `KSE_TONE_MS
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // AXI4-Lite write
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // AXI4-Lite read
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Key matrix and modifiers
   output logic [COLS-1:0] o_col,
   input wire logic [ROWS-1:0] i_row,
   input wire logic i_shift,
   input wire logic i_ctrl,
   // Code stream, tone and lights
   output logic [7:0] o_code,
   output logic o_code_valid,
   output logic o_tone,
   output logic [15:0] o_lights
);
   localparam int IW = $clog2(ROWS) + $clog2(COLS);
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
      return (v == '1) ? v : v + TW'(1);
   endfunction : sat_inc

   // ----------------------------------------------------------------
   // Modifier synchronisers
   // ----------------------------------------------------------------
   logic shift_m_r, shift_s_r, ctrl_m_r, ctrl_s_r;

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         shift_m_r <= 1'b0;
         shift_s_r <= 1'b0;
         ctrl_m_r <= 1'b0;
         ctrl_s_r <= 1'b0;
      end else begin
         shift_m_r <= i_shift;
         shift_s_r <= shift_m_r;
         ctrl_m_r <= i_ctrl;
         ctrl_s_r <= ctrl_m_r;
      end
   end

   // ----------------------------------------------------------------
   // Scanner and timers
   // ----------------------------------------------------------------
   logic found, locked, rpt_done, rpt_start, tone_start;
   logic [IW-1:0] key_idx;
   logic [TW-1:0] rpt_len;

   kse_scan #(.ROWS(ROWS), .COLS(COLS)) u_scan (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .o_col(o_col),
      .i_row(i_row),
      .o_found(found),
      .o_locked(locked),
      .o_key_idx(key_idx)
   );

   // The first repeat waits the full delay; later ones reload one cycle short for an exact period.
   assign rpt_start = found || (rpt_done && locked); // [RL1] [RL21]
   assign rpt_len = found ? TW'(RPT_DELAY_CYC) : TW'(RPT_PERIOD_CYC - 1); // [RL3] [RL4]

   kse_timer #(.TW(TW)) u_rpt (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_start(rpt_start),
      .i_len(rpt_len),
      .i_stop(!locked), // [RL1]
      .o_busy(),
      .o_done(rpt_done)
   );

   kse_timer #(.TW(TW)) u_tone (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_start(tone_start), // [RL11] [RL12]
      .i_len(TW'(TONE_CYC)),
      .i_stop(1'b0),
      .o_busy(o_tone),
      .o_done()
   );

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic [7:0] aw_addr_r, aw_addr_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic w_lane0_r, w_lane0_nxt;
   logic bvalid_nxt, rvalid_nxt, awready_nxt, wready_nxt, arready_nxt;
   logic [1:0] bresp_nxt, rresp_nxt;
   logic [31:0] rdata_nxt;
   logic wr_fire, rd_fire, kc_pop;
   logic tty_r, tty_nxt;
   logic [15:0] lights_nxt;
   logic kc_valid_r, kc_valid_nxt;
   logic [7:0] kc_code_r, kc_code_nxt;

   assign wr_fire = aw_have_r && w_have_r && !o_bvalid;
   assign rd_fire = i_arvalid && o_arready;
   assign kc_pop = rd_fire && i_araddr == `KSE_OFS_KEYCODE;
   assign tone_start = wr_fire && w_lane0_r && aw_addr_r == `KSE_OFS_HOSTCHAR
                       && w_data_r[7:0] == `KSE_BELL_CODE;

   always_comb begin
      aw_have_nxt = aw_have_r;
      aw_addr_nxt = aw_addr_r;
      w_have_nxt = w_have_r;
      w_data_nxt = w_data_r;
      w_lane0_nxt = w_lane0_r;
      bvalid_nxt = o_bvalid && !i_bready;
      bresp_nxt = o_bresp;
      rvalid_nxt = o_rvalid && !i_rready;
      rresp_nxt = o_rresp;
      rdata_nxt = o_rdata;
      tty_nxt = tty_r;
      lights_nxt = o_lights;
      if (i_awvalid && o_awready) begin
         aw_have_nxt = 1'b1;
         aw_addr_nxt = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         w_have_nxt = 1'b1;
         w_data_nxt = i_wdata;
         w_lane0_nxt = i_wstrb[0];
      end
      if (wr_fire) begin
         aw_have_nxt = 1'b0;
         w_have_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = RESP_OK;
         case (aw_addr_r)
            `KSE_OFS_CTRL: begin
               if (w_lane0_r) begin
                  tty_nxt = w_data_r[`KSE_CTRL_TTY_BIT];
               end
            end
            `KSE_OFS_LIGHTCMD: begin
               if (w_lane0_r) begin
                  lights_nxt[w_data_r[3:0]] = w_data_r[`KSE_LCMD_ON_BIT]; // [RL14] [RL15] [RL20]
               end
            end
            `KSE_OFS_HOSTCHAR: begin
               bresp_nxt = RESP_OK;
            end
            default: begin
               bresp_nxt = RESP_ERR;
            end
         endcase
      end
      if (rd_fire) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = RESP_OK;
         rdata_nxt = '0;
         case (i_araddr)
            `KSE_OFS_CTRL: rdata_nxt[`KSE_CTRL_TTY_BIT] = tty_r;
            `KSE_OFS_HOSTCHAR: rdata_nxt = '0;
            `KSE_OFS_LIGHTCMD: rdata_nxt = '0;
            `KSE_OFS_LIGHTS: rdata_nxt[15:0] = o_lights;
            `KSE_OFS_KEYCODE: rdata_nxt[8:0] = {kc_valid_r, kc_code_r};
            `KSE_OFS_STATUS: begin
               rdata_nxt[`KSE_STAT_TONE_BIT] = o_tone;
               rdata_nxt[`KSE_STAT_LOCK_BIT] = locked;
            end
            default: rresp_nxt = RESP_ERR;
         endcase
      end
      awready_nxt = !aw_have_nxt && !bvalid_nxt;
      wready_nxt = !w_have_nxt && !bvalid_nxt;
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_have_r <= 1'b0;
         w_data_r <= 32'h00000000;
         w_lane0_r <= 1'b0;
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_arready <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OK;
         o_rvalid <= 1'b0;
         o_rresp <= RESP_OK;
         o_rdata <= 32'h00000000;
         tty_r <= `KSE_RST_CTRL;
         o_lights <= `KSE_RST_LIGHTS;
      end else begin
         aw_have_r <= aw_have_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_have_r <= w_have_nxt;
         w_data_r <= w_data_nxt;
         w_lane0_r <= w_lane0_nxt;
         o_awready <= awready_nxt;
         o_wready <= wready_nxt;
         o_arready <= arready_nxt;
         o_bvalid <= bvalid_nxt;
         o_bresp <= bresp_nxt;
         o_rvalid <= rvalid_nxt;
         o_rresp <= rresp_nxt;
         o_rdata <= rdata_nxt;
         tty_r <= tty_nxt;
         o_lights <= lights_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Code issue
   // ----------------------------------------------------------------
   logic emit_req, emit_ok, code_valid_nxt;
   logic [7:0] code_w;
   logic emit_ctrl_r, emit_tty_r, emit_rpt_r, rpt_first_r;
   logic [IW-1:0] emit_idx_r, lock_idx_r;
   logic [TW-1:0] gap_r, tone_age_r;

   // Repeats reuse the locked key only, so output never alternates between keys.
   assign emit_req = found || (rpt_done && locked); // [RL2]
   assign code_w = kse_key_code(key_idx, shift_s_r, ctrl_s_r, tty_r);
   assign emit_ok = kse_ctrl_pass(code_w, ctrl_s_r); // [RL18]
   assign code_valid_nxt = emit_req && emit_ok;

   // A new code wins over a software read that pops the previous one.
   always_comb begin
      kc_valid_nxt = kc_valid_r;
      kc_code_nxt = kc_code_r;
      if (code_valid_nxt) begin
         kc_valid_nxt = 1'b1;
         kc_code_nxt = code_w;
      end else if (kc_pop) begin
         kc_valid_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_code <= 8'h00;
         o_code_valid <= 1'b0;
         kc_valid_r <= 1'b0;
         kc_code_r <= 8'h00;
      end else begin
         o_code <= emit_req ? code_w : o_code;
         o_code_valid <= code_valid_nxt;
         kc_valid_r <= kc_valid_nxt;
         kc_code_r <= kc_code_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         emit_ctrl_r <= 1'b0;
         emit_tty_r <= 1'b0;
         emit_rpt_r <= 1'b0;
         emit_idx_r <= '0;
         lock_idx_r <= '0;
         rpt_first_r <= 1'b0;
         gap_r <= '0;
         tone_age_r <= '0;
      end else begin
         emit_ctrl_r <= emit_req ? ctrl_s_r : emit_ctrl_r;
         emit_tty_r <= emit_req ? tty_r : emit_tty_r;
         emit_rpt_r <= emit_req && !found;
         emit_idx_r <= emit_req ? key_idx : emit_idx_r;
         lock_idx_r <= found ? key_idx : lock_idx_r;
         rpt_first_r <= found ? 1'b1 : (rpt_done ? 1'b0 : rpt_first_r);
         gap_r <= emit_req ? '0 : sat_inc(gap_r);
         tone_age_r <= tone_start ? '0 : sat_inc(tone_age_r);
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   bell_tone_a: assert property (tone_start |=> o_tone [*8]) // [RL11]
      else $error("Tone not raised after bell.");
   tone_end_a: assert property ($fell(o_tone) |-> tone_age_r == TW'(TONE_CYC)) // [RL12]
      else $error("Tone ended at wrong time after last bell.");
   lights_hold_a: assert property (!(wr_fire && aw_addr_r == `KSE_OFS_LIGHTCMD)
                                   |=> $stable(o_lights)) // [RL16]
      else $error("Lights changed without a light command.");
   tty_upper_a: assert property (o_code_valid && emit_tty_r
                                 |-> !(o_code >= `KSE_LOWER_MIN && o_code <= `KSE_LOWER_MAX)) // [RL17]
      else $error("Lower case code in uppercase mode.");
   ctrl_filter_a: assert property (o_code_valid && emit_ctrl_r
                                   |-> o_code <= `KSE_CTRL_MAX || o_code == `KSE_DEL_CODE
                                       || o_code >= `KSE_NONASCII_MIN) // [RL18]
      else $error("Blocked code sent under control.");
   cursor_code_a: assert property (o_code_valid && emit_idx_r >= IW'(`KSE_SECT_ALNUM_END)
                                   && emit_idx_r < IW'(`KSE_SECT_CURSOR_END)
                                   |-> o_code[0] == emit_ctrl_r) // [RL5]
      else $error("Cursor speed code wrong.");
   repeat_time_a: assert property (rpt_done && locked |-> gap_r ==
                                   (rpt_first_r ? TW'(RPT_DELAY_CYC) : TW'(RPT_PERIOD_CYC - 1))) // [RL1]
      else $error("Repeat delay or period wrong.");
   repeat_key_a: assert property (o_code_valid && emit_rpt_r |-> emit_idx_r == lock_idx_r) // [RL2]
      else $error("Repeat issued for a key other than the locked one.");

   key_code_c: cover property (o_code_valid);
   repeat_c: cover property (o_code_valid && emit_rpt_r);
   tone_c: cover property (tone_start ##[1:8] tone_start);

endmodule : kse_top

// file: design/kse_regs.svh
// Register offsets, field positions, reset values and timing figures of the keyboard encoder.
// Assumes inclusion by every design file that decodes registers, codes or timing.
// Operation
// [RL1] Held key repeats after one second.
// [RL2] Only the first recognised key repeats.
// [RL3] Repeat rate ten per second, baud independent.
// [RL4] Repeat delay and rate are fixed constants.
// [RL5] Cursor keys have slow and fast codes.
// [RL6] Recognised key halts scan, others ignored.
// [RL7] Scan resumes when locking key releases.
// [RL8] Held second key is recognised after release.
// [RL9] Several held keys yield one code.
// [RL10] Simultaneous presses yield one code.
// [RL11] Bell code sounds tone for one second.
// [RL12] Each bell restarts the tone timer.
// [RL13] Host resends bell for continuous tone.
// [RL14] Sixteen lights set only by host command.
// [RL15] Lights indexed 0 to 15, left to right.
// [RL16] Special keys never change the lights.
// [RL17] Uppercase mode lowers codes 140-176 by 40.
// [RL18] Control passes only 000-040, 177, 200-377.
// [RL19] Shift affects alphanumeric section codes only.
// [RL20] Light command: four-bit index, one on/off bit.
// [RL21] Delays and tone derived by system clock counters.
`ifndef KSE_REGS_SVH
`define KSE_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define KSE_OFS_CTRL 8'h00
`define KSE_OFS_HOSTCHAR 8'h04
`define KSE_OFS_LIGHTCMD 8'h08
`define KSE_OFS_LIGHTS 8'h0C
`define KSE_OFS_KEYCODE 8'h10
`define KSE_OFS_STATUS 8'h14

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define KSE_CTRL_TTY_BIT 0
`define KSE_LCMD_ON_BIT 4
`define KSE_KEYCODE_VALID_BIT 8
`define KSE_STAT_TONE_BIT 0
`define KSE_STAT_LOCK_BIT 1
`define KSE_RST_CTRL 1'h0
`define KSE_RST_LIGHTS 16'h0000

// ----------------------------------------------------------------
// Codes and key sections
// ----------------------------------------------------------------
`define KSE_BELL_CODE 8'h07
`define KSE_DEL_CODE 8'h7F
`define KSE_CTRL_MAX 8'h20
`define KSE_NONASCII_MIN 8'h80
`define KSE_LOWER_MIN 8'h60
`define KSE_LOWER_MAX 8'h7E
`define KSE_CASE_OFS 8'h20
`define KSE_SECT_LETTER_END 6'h20
`define KSE_SECT_ALNUM_END 6'h30
`define KSE_SECT_CURSOR_END 6'h35

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define KSE_CLK_HZ 25000000
`define KSE_RPT_DELAY_MS 1000
`define KSE_RPT_RATE_HZ 10
`define KSE_TONE_MS 1000
`define KSE_SCAN_DIV 16

`endif

// file: design/kse_pkg.sv
// Types and code tables of the keyboard encoder.
// Assumes the register header is on the include path.
`include "kse_regs.svh"
package kse_pkg;

   typedef enum logic [1:0] {
      KSE_SCAN = 2'b01,
      KSE_LOCK = 2'b10
   } kse_scan_st_t;

   // Code of a 64-key matrix position under the current shift, control and mode.
   function automatic logic [7:0] kse_key_code(input logic [5:0] idx, input logic shift,
                                               input logic ctrl, input logic tty);
      logic [7:0] c;
      c = 8'h00;
      if (idx < `KSE_SECT_LETTER_END) begin
         if (ctrl) begin
            c = {3'h0, idx[4:0]};
         end else if (shift) begin
            c = {3'h2, idx[4:0]};
         end else begin
            c = {3'h3, idx[4:0]};
         end
      end else if (idx < `KSE_SECT_ALNUM_END) begin
         c = shift ? {4'h2, idx[3:0]} : {4'h3, idx[3:0]};
      end else if (idx < `KSE_SECT_CURSOR_END) begin
         c = {4'h8, idx[2:0], ctrl}; // [RL5] [RL19]
      end else begin
         c = {2'h2, ctrl, idx[4:0]}; // [RL19]
      end
      if (tty && idx < `KSE_SECT_ALNUM_END && c >= `KSE_LOWER_MIN && c <= `KSE_LOWER_MAX) begin
         c = c - `KSE_CASE_OFS; // [RL17]
      end
      return c;
   endfunction : kse_key_code

   // True when a code may leave while the control key is held.
   function automatic logic kse_ctrl_pass(input logic [7:0] c, input logic ctrl);
      return !ctrl || c <= `KSE_CTRL_MAX || c == `KSE_DEL_CODE || c >= `KSE_NONASCII_MIN;
   endfunction : kse_ctrl_pass

endpackage : kse_pkg

// file: design/kse_timer.sv
// Retriggerable down counter with a busy level and a done pulse.
// Assumes start and stop come from logic on the same clock.
`timescale 1ns/10ps
module kse_timer #(
   parameter int TW = 26
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Control
   input wire logic i_start,
   input wire logic [TW-1:0] i_len,
   input wire logic i_stop,
   // Status
   output logic o_busy,
   output logic o_done
);
   logic [TW-1:0] cnt_r;
   logic [TW-1:0] cnt_nxt;
   logic busy_nxt;
   logic done_nxt;

   // A start reloads the count at any point of a running period.
   always_comb begin
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      if (i_start) begin
         cnt_nxt = i_len; // [RL12]
      end else if (i_stop) begin
         cnt_nxt = '0;
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - TW'(1);
         done_nxt = (cnt_r == TW'(1));
      end
      busy_nxt = (cnt_nxt != '0);
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         cnt_r <= '0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         o_busy <= busy_nxt;
         o_done <= done_nxt;
      end
   end

endmodule : kse_timer

// file: design/kse_scan.sv
// Key matrix scanner with n-key lockout and two-key rollover.
// Assumes keys pull their row high while their column is driven.
`timescale 1ns/10ps
`include "kse_regs.svh"
module kse_scan
   import kse_pkg::*;
#(
   parameter int ROWS = 8,
   parameter int COLS = 8,
   parameter int DIV = `KSE_SCAN_DIV,
   parameter int RW = $clog2(ROWS),
   parameter int CW = $clog2(COLS)
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Matrix
   output logic [COLS-1:0] o_col,
   input wire logic [ROWS-1:0] i_row,
   // Key events
   output logic o_found,
   output logic o_locked,
   output logic [RW+CW-1:0] o_key_idx
);
   localparam int DW = $clog2(DIV);

   function automatic logic [CW-1:0] next_col(input logic [CW-1:0] c);
      return (c == CW'(COLS - 1)) ? '0 : c + CW'(1);
   endfunction : next_col

   kse_scan_st_t st_r, st_nxt;
   logic [CW-1:0] col_r, col_nxt;
   logic [RW-1:0] row_r, row_nxt;
   logic [DW-1:0] div_r, div_nxt;
   logic [ROWS-1:0] row_m_r, row_s_r;
   logic [COLS-1:0] col_oh_nxt;
   logic found_nxt;
   logic tick;

   assign tick = (div_r == DW'(DIV - 1));
   assign o_locked = (st_r == KSE_LOCK);
   assign o_key_idx = {col_r, row_r};

   always_comb begin
      st_nxt = st_r;
      col_nxt = col_r;
      row_nxt = row_r;
      found_nxt = 1'b0;
      div_nxt = tick ? '0 : div_r + DW'(1);
      case (st_r)
         KSE_SCAN: begin
            if (tick && row_s_r != '0) begin
               for (int r = ROWS - 1; r >= 0; r--) begin
                  if (row_s_r[r]) begin
                     row_nxt = RW'(r); // [RL10]
                  end
               end
               st_nxt = KSE_LOCK; // [RL6]
               found_nxt = 1'b1;
            end else if (tick) begin
               col_nxt = next_col(col_r);
            end
         end
         KSE_LOCK: begin
            if (tick && !row_s_r[row_r]) begin
               st_nxt = KSE_SCAN; // [RL7] [RL8]
               col_nxt = next_col(col_r);
            end
         end
         default: begin
            st_nxt = KSE_SCAN;
         end
      endcase
      col_oh_nxt = '0;
      col_oh_nxt[col_nxt] = 1'b1;
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         st_r <= KSE_SCAN;
         col_r <= '0;
         row_r <= '0;
         div_r <= '0;
         row_m_r <= '0;
         row_s_r <= '0;
         o_col <= {{(COLS-1){1'b0}}, 1'b1};
         o_found <= 1'b0;
      end else begin
         st_r <= st_nxt;
         col_r <= col_nxt;
         row_r <= row_nxt;
         div_r <= div_nxt;
         row_m_r <= i_row;
         row_s_r <= row_m_r;
         o_col <= col_oh_nxt;
         o_found <= found_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   scan_halt_a: assert property (o_locked && $past(o_locked) |-> $stable(o_col)) // [RL6]
      else $error("Column moved while a key is locked.");
   single_code_a: assert property (o_found |=> !o_found [*4]) // [RL9]
      else $error("Two codes recognised back to back.");
   rollover_c: cover property (o_locked ##1 !o_locked ##[1:200] o_found);

endmodule : kse_scan

// file: sim/kse_keys.sv
// Behavioural key matrix standing in for the switches and the operator.
// Assumes one-hot active-high column drive; a row with no closed key is pulled low.
`timescale 1ns/10ps
module kse_keys (
   // Matrix
   input wire logic [7:0] i_col,
   input wire logic [63:0] i_pressed,
   // Rows
   output logic [7:0] o_row
);
   always_comb begin
      o_row = 8'h00;
      for (int c = 0; c < 8; c++) begin
         if (i_col[c]) begin
            o_row = o_row | i_pressed[c*8 +: 8];
         end
      end
   end
endmodule : kse_keys

// file: sim/kse_top_test.sv
// Self-checking bench of the keyboard encoder: register bus, keys, tone, lights.
// Assumes the key matrix model and shortened repeat and tone counts.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module kse_top_test;
   import kse_pkg::*;
   logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
   logic i_arvalid = 1'b0, i_rready = 1'b0, i_shift = 1'b0, i_ctrl = 1'b0;
   logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, o_col, i_row, o_code;
   logic [31:0] i_wdata = 32'h0, o_rdata, rd_d;
   logic [1:0] o_bresp, o_rresp, rsp;
   logic [3:0] i_wstrb = 4'hF;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_code_valid, o_tone;
   logic [15:0] o_lights;
   logic [63:0] keys = 64'h0;
   logic [7:0] cq[$];
   int tq[$];
   int cyc = 0, mismatches = 0, n_tests = 0, tl, t0;
   kse_top #(.RPT_DELAY_CYC(300), .RPT_PERIOD_CYC(40), .TONE_CYC(200)) DUT (.*);
   kse_keys u_keys (.i_col(o_col), .i_pressed(keys), .o_row(i_row));
   initial forever #20 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (i_rst_n && o_code_valid) begin
         cq.push_back(o_code);
         tq.push_back(cyc);
      end
      if (cyc == 60000) begin
         mismatches++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   // ----------------------------------------------------------------
   // Bus and key tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_awaddr <= a; i_wdata <= d; i_awvalid <= 1'b1; i_wvalid <= 1'b1; i_bready <= 1'b1;
      forever begin
         @(posedge i_sys_clk);
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
         if (o_bvalid) begin
            rsp = o_bresp; i_bready <= 1'b0; break;
         end
      end
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge i_sys_clk);
      i_araddr <= a; i_arvalid <= 1'b1; i_rready <= 1'b1;
      forever begin
         @(posedge i_sys_clk);
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
         if (o_rvalid) begin
            rd_d = o_rdata; rsp = o_rresp; i_rready <= 1'b0; break;
         end
      end
   endtask : rd
   task automatic got(input logic [7:0] e);
      int k;
      logic [7:0] c;
      k = 0;
      c = 8'hXX;
      tl = 0;
      while (cq.size() == 0 && k < 400) begin
         @(posedge i_sys_clk);
         k++;
      end
      if (cq.size() != 0) begin
         c = cq.pop_front();
         tl = tq.pop_front();
      end
      `CHK("code", e, c)
   endtask : got
   task automatic hit(input int k, input logic [7:0] e);
      keys[k] <= 1'b1;
      got(e);
      keys[k] <= 1'b0;
      repeat (40) @(posedge i_sys_clk);
   endtask : hit
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      rd(8'h00); `CHK("ctrl", 32'h0, rd_d)
      rd(8'h0C); `CHK("lights", 32'h0, rd_d)
      rd(8'h18); `CHK("unmapped", 2'h2, rsp)
      wr(8'h0C, 32'hFFFF); `CHK("ro write", 2'h2, rsp)
      wr(8'h08, 32'h10); wr(8'h08, 32'h1F); wr(8'h08, 32'h13); wr(8'h08, 32'h03);
      rd(8'h0C); `CHK("lights", 32'h8001, rd_d)
      keys[0] <= 1'b1;
      got(8'h60); t0 = tl;
      keys[9] <= 1'b1;
      got(8'h60); `CHK("delay", 301, tl - t0)
      t0 = tl;
      got(8'h60); `CHK("period", 40, tl - t0)
      keys[0] <= 1'b0;
      got(8'h69);
      keys[9] <= 1'b0;
      repeat (60) @(posedge i_sys_clk);
      `CHK("extra", 0, cq.size())
      `CHK("o_lights", 16'h8001, o_lights)
      hit(33, 8'h31);
      i_shift <= 1'b1;
      hit(33, 8'h21);
      hit(53, 8'h95);
      i_shift <= 1'b0;
      wr(8'h00, 32'h1);
      hit(1, 8'h41);
      hit(49, 8'h82);
      i_ctrl <= 1'b1;
      hit(48, 8'h81);
      hit(53, 8'hB5);
      hit(0, 8'h00);
      keys[35] <= 1'b1;
      repeat (200) @(posedge i_sys_clk);
      `CHK("suppressed", 0, cq.size())
      rd(8'h10); `CHK("keycode", 32'h100, rd_d)
      rd(8'h10); `CHK("keycode pop", 32'h0, rd_d)
      keys[35] <= 1'b0;
      i_ctrl <= 1'b0;
      wr(8'h04, 32'h41);
      repeat (2) @(posedge i_sys_clk);
      `CHK("no tone", 1'b0, o_tone)
      wr(8'h04, 32'h07);
      repeat (2) @(posedge i_sys_clk);
      `CHK("tone", 1'b1, o_tone)
      rd(8'h14); `CHK("status", 32'h1, rd_d)
      repeat (150) @(posedge i_sys_clk);
      wr(8'h04, 32'h07);
      repeat (150) @(posedge i_sys_clk);
      `CHK("tone held", 1'b1, o_tone)
      repeat (60) @(posedge i_sys_clk);
      `CHK("tone end", 1'b0, o_tone)
      conclude();
   end
endmodule : kse_top_test
